// ==== shared/data_config_pkg.sv ====
// Package with register map, field layout and decode types for the data configuration block.
package data_config_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] DATA_CONFIG_IDX  = 4'hE;
    localparam logic [3:0] DMA_STATUS_IDX   = 4'h0;
    localparam logic [3:0] RSTART_HI_IDX    = 4'h1;

    // ------------------------------------------------------------------
    // Field positions and reset value
    // ------------------------------------------------------------------
    localparam int         WTS_BIT          = 0;
    localparam int         BOS_BIT          = 1;
    localparam int         LAS_BIT          = 2;
    localparam int         LSEL_BIT         = 3;
    localparam int         AUTO_BIT         = 4;
    localparam int         FT_LO_BIT        = 5;
    localparam int         FT_HI_BIT        = 6;
    localparam logic [7:0] DATA_CONFIG_RST  = 8'h04;

    // ------------------------------------------------------------------
    // Threshold figures, in bytes
    // ------------------------------------------------------------------
    localparam logic [4:0] TX_THRESH_BASE   = 5'h0D;
    localparam logic [4:0] FIFO_DEPTH_BYTES = 5'h10;

    typedef struct packed {
        logic       auto_init;
        logic       loopback_sel;
        logic       long_address_sel;
        logic       byte_order_sel;
        logic       transfer_width_sel;
        logic [1:0] fifo_threshold;
    } config_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_BURST = 2'b01,
        ST_DONE  = 2'b11
    } dma_state_e;

endpackage : data_config_pkg

// ==== design/dma_data_config.sv ====
// Data configuration register and the DMA bus-side behaviour it steers.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Width bit 0 gives byte transfers, 1 gives word transfers, remote and local.
// - Word mode addresses up to 32k words with address bit 0 held low.
// - Byte order 0 puts high byte on upper lane; 1 swaps the lanes.
// - Byte order bit is ignored while byte-wide transfers are selected.
// - Long address bit 0 gives dual 16-bit channels, 1 gives single 32-bit.
// - In long address mode remote start address drives upper address lines.
// - Long address bit is set at power-up.
// - Loopback select 0 requests loopback, 1 is normal operation.
// - Auto-initialise set lets the send command run; clear blocks it.
// - Receive bus request at threshold 1, 2, 4 or 6 words, or 2, 4, 8, 12 bytes.
// - Transmit bus request threshold is thirteen bytes minus receive threshold.
// - Burst length follows the selected threshold.
module dma_data_config
    import data_config_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        transmit_mode,
    input  wire logic [4:0]  fifo_level,
    input  wire logic        send_cmd,
    input  wire logic [15:0] remote_start_addr,
    input  wire logic [15:0] dma_addr,
    input  wire logic [15:0] dma_wdata,
    input  wire logic        bus_grant,
    output logic             bus_request,
    output logic      [31:0] mem_addr,
    output logic      [15:0] mem_data,
    output logic             word_mode,
    output logic             loopback_req,
    output logic             send_start,
    output logic      [3:0]  burst_len
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Threshold in bytes for a code; code 00 is the smallest step.
    function automatic logic [4:0] rx_bytes(input logic [1:0] code);
        rx_bytes = (code == 2'b00) ? 5'h02 : {2'b00, code, 1'b0} << 1;
    endfunction : rx_bytes

    // Words needed to carry a byte count; an odd count rounds up so no burst is empty.
    function automatic logic [3:0] words_of(input logic [4:0] nbytes);
        words_of = 4'((nbytes + 5'h01) >> 1);
    endfunction : words_of

    config_s          cfg;
    logic [7:0]       data_config_q;
    logic             ack_q;
    logic             wr_hit;
    logic [4:0]       rx_thresh;
    logic [4:0]       tx_thresh;
    logic [4:0]       fill_bytes;
    logic [4:0]       thresh;
    logic [3:0]       burst_cnt_q;
    logic [3:0]       burst_cnt_d;
    dma_state_e       state_q;
    dma_state_e       state_d;
    logic [31:0]      addr_d;
    logic [15:0]      data_d;
    logic             send_q;

    assign cfg.transfer_width_sel = data_config_q[WTS_BIT];
    assign cfg.byte_order_sel     = data_config_q[BOS_BIT];
    assign cfg.long_address_sel   = data_config_q[LAS_BIT];
    assign cfg.loopback_sel       = data_config_q[LSEL_BIT];
    assign cfg.auto_init          = data_config_q[AUTO_BIT];
    assign cfg.fifo_threshold     = data_config_q[FT_HI_BIT:FT_LO_BIT];

    // ------------------------------------------------------------------
    // Wishbone slave: one-cycle ack, unmapped reads return zero.
    // ------------------------------------------------------------------
    assign wr_hit = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && wb_sel_i[0]
                    && (wb_adr_i == DATA_CONFIG_IDX);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end
    assign wb_ack_o = ack_q;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            data_config_q <= DATA_CONFIG_RST;
        end else if (wr_hit) begin
            data_config_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
            unique case (wb_adr_i)
                DMA_STATUS_IDX: wb_dat_o <= {24'h00_0000, 2'b00, burst_cnt_q, state_q};
                RSTART_HI_IDX:  wb_dat_o <= {16'h0000, remote_start_addr};
                default:        wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Thresholds and bus request
    // ------------------------------------------------------------------
    assign rx_thresh  = rx_bytes(cfg.fifo_threshold);
    assign tx_thresh  = TX_THRESH_BASE - rx_thresh;
    assign thresh     = transmit_mode ? tx_thresh : rx_thresh;
    // In word mode the level counts words, so compare in bytes.
    assign fill_bytes = cfg.transfer_width_sel ? (fifo_level << 1) : fifo_level;
    assign word_mode  = cfg.transfer_width_sel;
    assign loopback_req = !cfg.loopback_sel;

    // Burst length in transfers equals the threshold, in words or bytes.
    assign burst_len = cfg.transfer_width_sel ? words_of(thresh) : thresh[3:0];

    always_comb begin
        state_d     = state_q;
        burst_cnt_d = burst_cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                if (fill_bytes >= thresh) begin
                    state_d = ST_BURST;
                    burst_cnt_d = burst_len;
                end
            end
            ST_BURST: begin
                if (bus_grant) begin
                    burst_cnt_d = burst_cnt_q - 4'h1;
                    if (burst_cnt_q == 4'h1) begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q     <= ST_IDLE;
            burst_cnt_q <= 4'h0;
        end else begin
            state_q     <= state_d;
            burst_cnt_q <= burst_cnt_d;
        end
    end
    assign bus_request = (state_q == ST_BURST);

    // ------------------------------------------------------------------
    // Address and data lanes
    // ------------------------------------------------------------------
    always_comb begin
        addr_d = 32'h0000_0000;
        addr_d[15:0] = dma_addr;
        if (cfg.transfer_width_sel) begin
            addr_d[0] = 1'b0;
        end
        if (cfg.long_address_sel) begin
            addr_d[31:16] = remote_start_addr;
        end
    end

    always_comb begin
        data_d = dma_wdata;
        if (cfg.transfer_width_sel && cfg.byte_order_sel) begin
            data_d = {dma_wdata[7:0], dma_wdata[15:8]};
        end else if (!cfg.transfer_width_sel) begin
            data_d = {8'h00, dma_wdata[7:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mem_addr <= 32'h0000_0000;
            mem_data <= 16'h0000;
        end else begin
            mem_addr <= addr_d;
            mem_data <= data_d;
        end
    end

    // ------------------------------------------------------------------
    // Send command gating
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            send_q <= 1'b0;
        end else begin
            send_q <= send_cmd && cfg.auto_init;
        end
    end
    assign send_start = send_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_word_addr_even: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(cfg.transfer_width_sel) |-> mem_addr[0] == 1'b0)
        else $error("word mode address bit 0 not low");
    a_upper_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(cfg.long_address_sel) |-> mem_addr[31:16] == $past(remote_start_addr))
        else $error("upper address does not follow remote start address");
    a_dual_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$past(cfg.long_address_sel) |-> mem_addr[31:16] == 16'h0000)
        else $error("upper address driven in dual mode");
    a_lane_swap: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(cfg.transfer_width_sel && cfg.byte_order_sel)
        |-> mem_data == {$past(dma_wdata[7:0]), $past(dma_wdata[15:8])})
        else $error("byte lanes not swapped");
    a_byte_no_order: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$past(cfg.transfer_width_sel) |-> mem_data[15:8] == 8'h00)
        else $error("byte mode uses upper lane");
    a_send_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
        send_cmd && !cfg.auto_init |=> !send_start)
        else $error("send started without auto init");
    a_tx_thresh_sum: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_thresh + rx_thresh == 5'h0D)
        else $error("transmit threshold wrong");
    a_req_on_fill: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_IDLE && fill_bytes >= thresh |=> bus_request)
        else $error("bus request not raised at threshold");
    a_burst_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(bus_request) |-> burst_cnt_q == $past(burst_len))
        else $error("burst length not loaded");
    a_loopback_out: assert property (@(posedge ref_clk) disable iff (!nrst)
        loopback_req == !data_config_q[LSEL_BIT])
        else $error("loopback output mismatch");

    // ------------------------------------------------------------------
    // Register bus checks
    // ------------------------------------------------------------------
    // The slave answers every request after exactly one cycle.
    a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_needs_req: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    a_cfg_stores_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        nrst && wr_hit |=> data_config_q == $past(wb_dat_i[7:0]))
        else $error("configuration write not stored");
    a_cfg_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
        nrst && !wr_hit |=> $stable(data_config_q))
        else $error("configuration changed without a write");
    a_write_only_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == DATA_CONFIG_IDX
        |-> wb_dat_o == 32'h0000_0000)
        else $error("write-only configuration readable");

    // ------------------------------------------------------------------
    // Burst checks
    // ------------------------------------------------------------------
    // The request stays low below the threshold and a burst ends after its last granted transfer.
    a_no_req_below: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_IDLE && fill_bytes < thresh |=> !bus_request)
        else $error("bus request raised below threshold");
    a_burst_dec: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BURST && bus_grant |=> burst_cnt_q == $past(burst_cnt_q) - 4'h1)
        else $error("granted transfer not counted");
    a_burst_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BURST && !bus_grant |=> bus_request && $stable(burst_cnt_q))
        else $error("burst moved without a grant");
    a_burst_end: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BURST && bus_grant && burst_cnt_q == 4'h1 |=> state_q == ST_DONE)
        else $error("burst did not end after last transfer");
    a_done_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_DONE |=> state_q == ST_IDLE)
        else $error("done state not left");
    a_done_no_req: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_DONE |-> !bus_request)
        else $error("bus request high after burst");
    a_burst_nonzero: assert property (@(posedge ref_clk) disable iff (!nrst)
        bus_request |-> burst_cnt_q != 4'h0)
        else $error("burst counter empty while requesting");
    a_burst_len_nonzero: assert property (@(posedge ref_clk) disable iff (!nrst)
        burst_len != 4'h0)
        else $error("burst length zero");
    a_rx_thresh_codes: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_thresh == 5'h02 || rx_thresh == 5'h04 || rx_thresh == 5'h08 || rx_thresh == 5'h0C)
        else $error("receive threshold outside the coded steps");
    a_code_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg.fifo_threshold == 2'b00 |-> rx_thresh == 5'h02)
        else $error("code zero threshold wrong");
    a_tx_below_base: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_thresh < TX_THRESH_BASE)
        else $error("transmit threshold not below base");
    a_state_legal: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_IDLE || state_q == ST_BURST || state_q == ST_DONE)
        else $error("illegal burst state");

    // ------------------------------------------------------------------
    // Lane checks
    // ------------------------------------------------------------------
    // The first cycle after reset is skipped, as the lanes still hold reset values.
    a_word_no_swap: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst && cfg.transfer_width_sel && !cfg.byte_order_sel)
        |-> mem_data == $past(dma_wdata))
        else $error("word lanes altered without byte order");
    a_byte_low_lane: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst && !cfg.transfer_width_sel) |-> mem_data[7:0] == $past(dma_wdata[7:0]))
        else $error("byte mode low lane wrong");
    a_low_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> mem_addr[15:1] == $past(dma_addr[15:1]))
        else $error("lower address does not follow the DMA address");
    a_byte_addr_bit0: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst && !cfg.transfer_width_sel) |-> mem_addr[0] == $past(dma_addr[0]))
        else $error("byte mode address bit 0 altered");

    // ------------------------------------------------------------------
    // Send checks
    // ------------------------------------------------------------------
    a_send_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
        nrst && send_cmd && cfg.auto_init |=> send_start)
        else $error("send not started with auto init");
    a_send_needs_cmd: assert property (@(posedge ref_clk) disable iff (!nrst)
        !$past(send_cmd) |-> !send_start)
        else $error("send started without a command");

endmodule : dma_data_config

`default_nettype wire

// ==== test/mem_bus_model.sv ====
// Memory-side bus partner that grants the system bus, promptly or after stalls.
`timescale 1ns/1ns
`default_nettype none
module mem_bus_model (
    input  wire logic nrst,
    input  wire logic bus_request,
    input  wire logic stall,
    output logic      bus_grant
);
    // A stalled cycle grants nothing, so the burst must wait for the next one.
    assign bus_grant = nrst && bus_request && !stall;
endmodule : mem_bus_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the data configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import data_config_pkg::*;
    logic        ref_clk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, transmit_mode;
    logic        send_cmd, bus_grant, bus_request, word_mode, loopback_req, send_start;
    logic        stall, rd_pend;
    logic [3:0]  wb_adr_i, wb_sel_i, burst_len;
    logic [31:0] wb_dat_i, wb_dat_o, mem_addr, seed, r;
    logic [4:0]  fifo_level;
    logic [15:0] remote_start_addr, dma_addr, dma_wdata, mem_data;
    logic [31:0] exp_q[$];
    int          smp, mismatches, n_compared, thr, lvl, n, gcnt;
    int          th_tab[4] = '{2, 4, 8, 12};

    dma_data_config i_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .transmit_mode(transmit_mode), .fifo_level(fifo_level), .send_cmd(send_cmd),
        .remote_start_addr(remote_start_addr), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .bus_grant(bus_grant), .bus_request(bus_request), .mem_addr(mem_addr),
        .mem_data(mem_data), .word_mode(word_mode), .loopback_req(loopback_req),
        .send_start(send_start), .burst_len(burst_len));
    mem_bus_model i_mem (.nrst(nrst), .bus_request(bus_request), .stall(stall),
        .bus_grant(bus_grant));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] pick(input int k);
        case (k)
            3: return {16'h0, mem_data};
            4: return {31'h0, bus_request};
            5: return {29'h0, word_mode, loopback_req, send_start};
            6: return {28'h0, burst_len};
            7: return {16'h0, mem_addr[31:16]};
            8: return {31'h0, mem_addr[0]};
            default: return {27'h0, 5'(gcnt)};
        endcase
    endfunction : pick

    task automatic chk(input logic [31:0] got);
        logic [31:0] e;
        e = exp_q.pop_front();
        n_compared++;
        if (got !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, e);
        end
    endtask : chk

    // ------------------------------------------------------------------
    // Monitor: the oldest note is taken off as each result appears.
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (wb_ack_o && rd_pend) chk(wb_dat_o);
        else if (smp != 0) chk(pick(smp));
    end

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        rd_pend  <= !we;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        rd_pend  <= 1'b0;
        if (k >= 50) mismatches++;
        @(posedge ref_clk);
    endtask : wb

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic look(input int k, input logic [31:0] e);
        @(posedge ref_clk);
        exp_q.push_back(e);
        smp <= k;
        @(posedge ref_clk);
        smp <= 0;
    endtask : look

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        results();
    end

    initial begin
        {nrst, wb_we_i, wb_cyc_i, wb_stb_i, transmit_mode, send_cmd, rd_pend} = '0;
        {wb_adr_i, wb_dat_i, fifo_level, dma_addr, dma_wdata} = '0;
        wb_sel_i = 4'hF;
        remote_start_addr = 16'h0;
        stall = 1'b1;
        smp = 0;
        seed = 32'h7E1A8D6E;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        remote_start_addr <= 16'hA5C3;
        look(5, 32'h2);
        look(7, 32'hA5C3);
        rd(DATA_CONFIG_IDX, 32'h0);
        rd(RSTART_HI_IDX, 32'hA5C3);
        rd(DMA_STATUS_IDX, 32'h0);
        wb(1'b1, 4'h7, 32'hFF);
        rd(4'h7, 32'h0);
        $display("test reset and registers done");
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            wb(1'b1, DATA_CONFIG_IDX, 32'h0C | i);
            dma_wdata <= r[15:0];
            dma_addr  <= r[31:16];
            look(3, {16'h0, i[0] ? (i[1] ? {r[7:0], r[15:8]} : r[15:0]) : {8'h0, r[7:0]}});
            if (i[0]) look(8, 32'h0);
            look(5, {29'h0, i[0], 2'b00});
        end
        wb(1'b1, DATA_CONFIG_IDX, 32'h08);
        look(7, 32'h0);
        $display("test data lanes done");
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, DATA_CONFIG_IDX, i[0] ? 32'h1C : 32'h04);
            send_cmd <= 1'b1;
            @(posedge ref_clk);
            send_cmd <= 1'b0;
            exp_q.push_back({30'h0, !i[0], i[0]});
            smp <= 5;
            @(posedge ref_clk);
            smp <= 0;
        end
        $display("test send and loopback done");
        for (int j = 0; j < 16; j++) begin
            thr = j[2] ? 13 - th_tab[j[1:0]] : th_tab[j[1:0]];
            lvl = j[3] ? (thr + 1) / 2 : thr;
            stall <= 1'b1;
            fifo_level <= 5'h0;
            transmit_mode <= j[2];
            wb(1'b1, DATA_CONFIG_IDX, {24'h0, 1'b0, 2'(j), 4'b0110, j[3]});
            fifo_level <= 5'(lvl - 1);
            look(4, 32'h0);
            fifo_level <= 5'(lvl);
            look(4, 32'h1);
            look(6, lvl);
            fifo_level <= 5'h0;
            gcnt = 0;
            n = 0;
            while (bus_request && n < 200) begin
                r = rnd();
                stall <= r[0];
                @(posedge ref_clk);
                if (bus_request && bus_grant) gcnt++;
                n++;
            end
            stall <= 1'b1;
            look(9, lvl);
        end
        $display("test thresholds and bursts done");
        results();
    end
endmodule : tb_top
`default_nettype wire
